// [hw/bsp_pin_route.sv]
`timescale 1ns/1ps
module bsp_pin_route (
  input  wire logic       ecc_sel,
  input  wire logic       audio_sel,
  input  wire logic [7:0] ecc_check_bits_out,
  input  wire logic [7:0] ecc_check_bits_oe,
  input  wire logic [7:0] gpio_hi_out,
  input  wire logic [7:0] gpio_hi_oe,
  input  wire logic [7:0] cb_pin_in,
  output logic      [7:0] cb_pin_out,
  output logic      [7:0] cb_pin_oe,
  output logic      [7:0] ecc_check_bits_in,
  output logic      [7:0] gpio_hi_in,
  input  wire logic [3:0] dma_req_in,
  output logic      [3:0] dma_request_pins,
  input  wire logic       dma_gnt2_out,
  output logic            dma_grant2_pin,
  input  wire logic       audio_reset_n,
  input  wire logic       audio_sync,
  input  wire logic       audio_sdout,
  output logic            audio_sdin,
  output logic            audio_bitclk,
  input  wire logic [4:2] gpio_lo_out,
  input  wire logic [4:2] gpio_lo_oe,
  input  wire logic [4:2] gpio_lo_pin_in,
  output logic      [4:2] gpio_lo_pin_out,
  output logic      [4:2] gpio_lo_pin_oe,
  output logic      [4:2] gpio_lo_in
);

  // check-bit pins: ecc or general io bits 15..8 in the same order
  always_comb begin
    cb_pin_out        = ecc_sel ? ecc_check_bits_out : gpio_hi_out;
    cb_pin_oe         = ecc_sel ? ecc_check_bits_oe  : gpio_hi_oe;
    ecc_check_bits_in = ecc_sel ? cb_pin_in : 8'h00;
    gpio_hi_in        = ecc_sel ? 8'h00 : cb_pin_in;
  end

  // audio routing looks only at audio_sel, ecc routing only at ecc_sel
  always_comb begin
    dma_request_pins    = dma_req_in;
    dma_grant2_pin      = dma_gnt2_out;
    gpio_lo_pin_out     = gpio_lo_out;
    gpio_lo_pin_oe      = gpio_lo_oe;
    gpio_lo_in          = gpio_lo_pin_in;
    audio_sdin          = 1'b0;
    audio_bitclk        = 1'b0;
    if (audio_sel) begin
      // pin 2 of the request group is driven as the link reset output
      dma_request_pins[2] = audio_reset_n;
      dma_grant2_pin      = audio_sync;
      gpio_lo_pin_out[4]  = audio_sdout;
      gpio_lo_pin_oe      = 3'h1 << 2;
      audio_sdin          = gpio_lo_pin_in[3];
      audio_bitclk        = gpio_lo_pin_in[2];
      gpio_lo_pin_out[3]  = 1'b0;
      gpio_lo_pin_out[2]  = 1'b0;
      gpio_lo_in          = 3'h0;
    end
  end

endmodule

// [hw/bsp_strap_loader.sv]
`timescale 1ns/1ps
module bsp_strap_loader (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [15:0] strap_data,
  input  wire logic [19:0] strap_addr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  board_boot_field,
  output logic             core_timer_irq_off,
  output logic             arbiter_select,
  output logic             byte_strobe_style,
  output logic      [1:0]  wait_ack_mode,
  output logic      [1:0]  boot_width,
  output logic             ecc_sel,
  output logic             audio_sel,
  input  wire logic [7:0]  ecc_check_bits_out,
  input  wire logic [7:0]  ecc_check_bits_oe,
  input  wire logic [7:0]  gpio_hi_out,
  input  wire logic [7:0]  gpio_hi_oe,
  input  wire logic [7:0]  cb_pin_in,
  output logic      [7:0]  cb_pin_out,
  output logic      [7:0]  cb_pin_oe,
  output logic      [7:0]  ecc_check_bits_in,
  output logic      [7:0]  gpio_hi_in,
  input  wire logic [3:0]  dma_req_in,
  output logic      [3:0]  dma_request_pins,
  input  wire logic        dma_gnt2_out,
  output logic             dma_grant2_pin,
  input  wire logic        audio_reset_n,
  input  wire logic        audio_sync,
  input  wire logic        audio_sdout,
  output logic             audio_sdin,
  output logic             audio_bitclk,
  input  wire logic [4:2]  gpio_lo_out,
  input  wire logic [4:2]  gpio_lo_oe,
  input  wire logic [4:2]  gpio_lo_pin_in,
  output logic      [4:2]  gpio_lo_pin_out,
  output logic      [4:2]  gpio_lo_pin_oe,
  output logic      [4:2]  gpio_lo_in
);

  ////////////////////////////////////////////////////////////////////////////
  logic        reset_d_ff;
  logic        capture;
  logic [7:0]  board_boot_field_ff;
  logic        timer_off_ff;
  logic        arb_ff;
  logic        strobe_ff;
  logic [1:0]  wait_ff;
  logic [1:0]  width_ff;
  logic        ecc_sel_ff;
  logic        audio_sel_ff;
  logic [15:0] raw_data_ff;
  logic [3:0]  raw_addr_ff;
  logic        wr_en;
  logic        rd_hit;
  logic [31:0] nxt_prdata;
  logic [31:0] prdata_ff;

  // capture happens on the first edge after reset falls; the straps seen there
  // are the ones present at release, so the board must hold them one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reset_d_ff <= 1'b1;
    end else begin
      reset_d_ff <= 1'b0;
    end
  end

  assign capture = reset_d_ff && !reset;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] target);
    addr_is = (a == target);
  endfunction

  assign wr_en = psel && penable && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // chip configuration fields
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      board_boot_field_ff      <= bsp_pkg::RST_CHIP_CONFIG[7:0];
      timer_off_ff <= bsp_pkg::RST_CHIP_CONFIG[bsp_pkg::CC_TIMER_BIT];
      arb_ff       <= bsp_pkg::RST_CHIP_CONFIG[bsp_pkg::CC_ARB_BIT];
    end else if (capture) begin
      board_boot_field_ff      <= strap_data[bsp_pkg::DATA_BOARD_BOOT_FIELD_LSB +: bsp_pkg::DATA_BOARD_BOOT_FIELD_W];
      timer_off_ff <= !strap_data[bsp_pkg::DATA_TIMER_BIT];
      arb_ff       <= strap_data[bsp_pkg::DATA_ARB_BIT];
    end else if (wr_en && addr_is(paddr, bsp_pkg::ADDR_CHIP_CONFIG)) begin
      board_boot_field_ff      <= pwdata[bsp_pkg::CC_BOARD_BOOT_FIELD_LSB +: 8];
      timer_off_ff <= pwdata[bsp_pkg::CC_TIMER_BIT];
      arb_ff       <= pwdata[bsp_pkg::CC_ARB_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external bus channel 0 control fields
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strobe_ff <= bsp_pkg::RST_EXT_BUS_CH0[bsp_pkg::EB_STROBE_BIT];
      wait_ff   <= bsp_pkg::RST_EXT_BUS_CH0[bsp_pkg::EB_WAIT_LSB +: 2];
      width_ff  <= bsp_pkg::RST_EXT_BUS_CH0[bsp_pkg::EB_WIDTH_LSB +: 2];
    end else if (capture) begin
      strobe_ff  <= strap_data[bsp_pkg::DATA_STROBE_BIT];
      wait_ff[0] <= strap_data[bsp_pkg::DATA_WAIT_BIT];
      width_ff   <= strap_data[bsp_pkg::DATA_WIDTH_LSB +: 2];
    end else if (wr_en && addr_is(paddr, bsp_pkg::ADDR_EXT_BUS_CH0)) begin
      strobe_ff <= pwdata[bsp_pkg::EB_STROBE_BIT];
      wait_ff   <= pwdata[bsp_pkg::EB_WAIT_LSB +: bsp_pkg::EB_WAIT_W];
      width_ff  <= pwdata[bsp_pkg::EB_WIDTH_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin mux selections, latched from the address straps
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ecc_sel_ff   <= bsp_pkg::RST_PIN_MUX[bsp_pkg::PM_ECC_BIT];
      audio_sel_ff <= bsp_pkg::RST_PIN_MUX[bsp_pkg::PM_AUDIO_BIT];
    end else if (capture) begin
      ecc_sel_ff   <= strap_addr[bsp_pkg::ADDR_ECC_BIT];
      audio_sel_ff <= strap_addr[bsp_pkg::ADDR_AUDIO_BIT];
    end else if (wr_en && addr_is(paddr, bsp_pkg::ADDR_PIN_MUX)) begin
      ecc_sel_ff   <= pwdata[bsp_pkg::PM_ECC_BIT];
      audio_sel_ff <= pwdata[bsp_pkg::PM_AUDIO_BIT];
    end
  end

  // raw strap snapshot for software inspection, read only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      raw_data_ff <= 16'h0000;
      raw_addr_ff <= 4'h0;
    end else if (capture) begin
      raw_data_ff <= strap_data;
      raw_addr_ff <= {2'h0, strap_addr[bsp_pkg::ADDR_ECC_BIT],
                      strap_addr[bsp_pkg::ADDR_AUDIO_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped reads zero with slave error
  assign pready = 1'b1;
  assign rd_hit = addr_is(paddr, bsp_pkg::ADDR_CHIP_CONFIG) ||
                  addr_is(paddr, bsp_pkg::ADDR_EXT_BUS_CH0) ||
                  addr_is(paddr, bsp_pkg::ADDR_PIN_MUX) ||
                  addr_is(paddr, bsp_pkg::ADDR_STRAP_RAW);
  assign pslverr = psel && penable && !rd_hit;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (addr_is(paddr, bsp_pkg::ADDR_CHIP_CONFIG)) begin
        nxt_prdata[bsp_pkg::CC_BOARD_BOOT_FIELD_LSB +: 8]  = board_boot_field_ff;
        nxt_prdata[bsp_pkg::CC_TIMER_BIT]      = timer_off_ff;
        nxt_prdata[bsp_pkg::CC_ARB_BIT]        = arb_ff;
      end else if (addr_is(paddr, bsp_pkg::ADDR_EXT_BUS_CH0)) begin
        nxt_prdata[bsp_pkg::EB_WIDTH_LSB +: 2] = width_ff;
        nxt_prdata[bsp_pkg::EB_WAIT_LSB +: 2]  = wait_ff;
        nxt_prdata[bsp_pkg::EB_STROBE_BIT]     = strobe_ff;
      end else if (addr_is(paddr, bsp_pkg::ADDR_PIN_MUX)) begin
        nxt_prdata[bsp_pkg::PM_ECC_BIT]        = ecc_sel_ff;
        nxt_prdata[bsp_pkg::PM_AUDIO_BIT]      = audio_sel_ff;
      end else if (addr_is(paddr, bsp_pkg::ADDR_STRAP_RAW)) begin
        nxt_prdata[15:0]  = raw_data_ff;
        nxt_prdata[19:16] = raw_addr_ff;
      end
    end
  end

  // read data is taken in the setup phase so the access phase sees a flop and
  // zero wait states survive; a read whose setup lands on the capture edge
  // returns the reset image, so software must not read in that one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata             = prdata_ff;
  assign board_boot_field   = board_boot_field_ff;
  assign core_timer_irq_off = timer_off_ff;
  assign arbiter_select     = arb_ff;
  assign byte_strobe_style  = strobe_ff;
  assign wait_ack_mode      = wait_ff;
  assign boot_width         = width_ff;
  assign ecc_sel            = ecc_sel_ff;
  assign audio_sel          = audio_sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // both ecc and upper io use the same pins; a board that wants both gets
  // whichever ecc_sel says, which is the only safe reading
  bsp_pin_route u_route (
    .ecc_sel            (ecc_sel_ff),
    .audio_sel          (audio_sel_ff),
    .ecc_check_bits_out (ecc_check_bits_out),
    .ecc_check_bits_oe  (ecc_check_bits_oe),
    .gpio_hi_out        (gpio_hi_out),
    .gpio_hi_oe         (gpio_hi_oe),
    .cb_pin_in          (cb_pin_in),
    .cb_pin_out         (cb_pin_out),
    .cb_pin_oe          (cb_pin_oe),
    .ecc_check_bits_in  (ecc_check_bits_in),
    .gpio_hi_in         (gpio_hi_in),
    .dma_req_in         (dma_req_in),
    .dma_request_pins   (dma_request_pins),
    .dma_gnt2_out       (dma_gnt2_out),
    .dma_grant2_pin     (dma_grant2_pin),
    .audio_reset_n      (audio_reset_n),
    .audio_sync         (audio_sync),
    .audio_sdout        (audio_sdout),
    .audio_sdin         (audio_sdin),
    .audio_bitclk       (audio_bitclk),
    .gpio_lo_out        (gpio_lo_out),
    .gpio_lo_oe         (gpio_lo_oe),
    .gpio_lo_pin_in     (gpio_lo_pin_in),
    .gpio_lo_pin_out    (gpio_lo_pin_out),
    .gpio_lo_pin_oe     (gpio_lo_pin_oe),
    .gpio_lo_in         (gpio_lo_in)
  );

endmodule

// [inc/bsp_pkg.sv]
package bsp_pkg;

  // register byte addresses
  localparam logic [11:0] ADDR_CHIP_CONFIG   = 12'h000;
  localparam logic [11:0] ADDR_EXT_BUS_CH0   = 12'h004;
  localparam logic [11:0] ADDR_PIN_MUX       = 12'h008;
  localparam logic [11:0] ADDR_STRAP_RAW     = 12'h00C;

  // strap data bus positions
  localparam int DATA_BOARD_BOOT_FIELD_LSB   = 8;
  localparam int DATA_BOARD_BOOT_FIELD_W     = 8;
  localparam int DATA_TIMER_BIT  = 7;
  localparam int DATA_STROBE_BIT = 5;
  localparam int DATA_WAIT_BIT   = 4;
  localparam int DATA_ARB_BIT    = 2;
  localparam int DATA_WIDTH_LSB  = 0;
  localparam int DATA_STRAP_W    = 16;

  // strap address bus positions
  localparam int ADDR_ECC_BIT    = 18;
  localparam int ADDR_AUDIO_BIT  = 9;
  localparam int ADDR_STRAP_W    = 20;

  // chip_config_reg layout
  localparam int CC_BOARD_BOOT_FIELD_LSB     = 0;
  localparam int CC_TIMER_BIT    = 8;
  localparam int CC_ARB_BIT      = 9;

  // ext_bus_ch0_ctrl layout
  localparam int EB_WIDTH_LSB    = 0;
  localparam int EB_WAIT_LSB     = 2;
  localparam int EB_WAIT_W       = 2;
  localparam int EB_STROBE_BIT   = 4;

  // pin mux register layout
  localparam int PM_ECC_BIT      = 0;
  localparam int PM_AUDIO_BIT    = 1;

  // reset values before any strap capture
  localparam logic [31:0] RST_CHIP_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_EXT_BUS_CH0 = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_MUX     = 32'h0000_0000;

  // boot width encodings
  localparam logic [1:0] WIDTH_RSVD = 2'h0;
  localparam logic [1:0] WIDTH_32   = 2'h1;
  localparam logic [1:0] WIDTH_16   = 2'h2;
  localparam logic [1:0] WIDTH_8    = 2'h3;

endpackage

// [tb/bsp_board_straps.sv]
`timescale 1ns/1ps
module bsp_board_straps (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [15:0] data_pat,
  input  wire logic [19:0] addr_pat,
  output logic      [15:0] strap_data,
  output logic      [19:0] strap_addr
);
  logic hold_ff;
  // straps held one cycle past release, through the capture edge; after it the bus carries other traffic
  always_ff @(posedge ref_clk) begin
    hold_ff <= reset;
  end
  // one select bit per function, so ecc and upper io are never both requested
  assign strap_data = (reset || hold_ff) ? data_pat : ~data_pat;
  assign strap_addr = (reset || hold_ff) ? addr_pat : ~addr_pat;
endmodule

// [tb/bsp_strap_sva.sv]
`timescale 1ns/1ps
module bsp_strap_sva (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [15:0] strap_data,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  board_boot_field,
  input wire logic        core_timer_irq_off,
  input wire logic        arbiter_select,
  input wire logic        byte_strobe_style,
  input wire logic [1:0]  wait_ack_mode,
  input wire logic [1:0]  boot_width,
  input wire logic        ecc_sel,
  input wire logic        audio_sel,
  input wire logic [7:0]  ecc_check_bits_out,
  input wire logic [7:0]  gpio_hi_out,
  input wire logic [7:0]  cb_pin_out,
  input wire logic [3:0]  dma_req_in,
  input wire logic [3:0]  dma_request_pins,
  input wire logic        audio_reset_n
);
  logic        prev_ff;
  logic        cap_ff;
  logic [15:0] data_ff;
  // cap_ff marks the first cycle in which captured straps must show
  always_ff @(posedge ref_clk) begin
    prev_ff <= reset;
    cap_ff  <= prev_ff & ~reset;
    data_ff <= strap_data;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_boot_field: assert property (cap_ff |-> board_boot_field == data_ff[15:8])
    else $error("boot field not captured");
  chk_timer_off: assert property (cap_ff |-> core_timer_irq_off == !data_ff[7])
    else $error("timer disable wrong");
  chk_ch0_fields: assert property (cap_ff |-> byte_strobe_style == data_ff[5] &&
    wait_ack_mode == {1'b0, data_ff[4]} && boot_width == data_ff[1:0] &&
    arbiter_select == data_ff[2])
    else $error("channel 0 or arbiter field wrong");
  chk_ecc_route: assert property (ecc_sel |-> cb_pin_out == ecc_check_bits_out)
    else $error("check bits not routed");
  chk_gpio_route: assert property (!ecc_sel |-> cb_pin_out == gpio_hi_out)
    else $error("upper io not routed");
  chk_audio_route: assert property (audio_sel |-> dma_request_pins[2] == audio_reset_n)
    else $error("audio reset not routed");
  chk_dma_keep: assert property ({dma_request_pins[3], dma_request_pins[1:0]} ==
    {dma_req_in[3], dma_req_in[1:0]})
    else $error("unshared dma pin disturbed");
  chk_field_hold: assert property (!cap_ff && !$past(psel && penable && pwrite) |->
    $stable({board_boot_field, core_timer_irq_off, boot_width}))
    else $error("latched field moved");
endmodule
bind bsp_strap_loader bsp_strap_sva u_sva (.*);

// [tb/tb_boot_strap_pin_mux.sv]
`timescale 1ns/1ps
module tb_boot_strap_pin_mux;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, e;
  logic        pready, pslverr, er, core_timer_irq_off, arbiter_select, byte_strobe_style;
  logic        ecc_sel, audio_sel, dma_gnt2_out, dma_grant2_pin, audio_reset_n, audio_sync;
  logic        audio_sdout, audio_sdin, audio_bitclk;
  logic [1:0]  wait_ack_mode, boot_width;
  logic [3:0]  dma_req_in, dma_request_pins;
  logic [4:2]  gpio_lo_out, gpio_lo_pin_in, gpio_lo_pin_out, gpio_lo_pin_oe, gpio_lo_in;
  logic [4:2]  gpio_lo_oe = 3'h5;
  logic [7:0]  ecc_check_bits_oe = 8'hF0;
  logic [7:0]  gpio_hi_oe = 8'h0F;
  logic [7:0]  board_boot_field, ecc_check_bits_out, gpio_hi_out, cb_pin_in, cb_pin_out;
  logic [7:0]  cb_pin_oe, ecc_check_bits_in, gpio_hi_in;
  logic [15:0] strap_data, d;
  logic [15:0] bd = 16'h0000;
  logic [19:0] strap_addr, a;
  logic [19:0] ba = 20'h0_0000;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [15:0] pats [4] = '{16'h12B5, 16'hED4A, 16'h00FF, 16'hFF00};

  always #12.5 ref_clk = ~ref_clk;

  bsp_strap_loader dut (.*);
  bsp_board_straps board (.ref_clk(ref_clk), .reset(reset), .data_pat(bd), .addr_pat(ba),
                          .strap_data(strap_data), .strap_addr(strap_addr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // shared and dedicated sources always differ so a wrong mux shows
  task automatic set_pins(input logic [7:0] v);
    ecc_check_bits_out <= v;
    gpio_hi_out <= v ^ 8'h3C;
    cb_pin_in <= ~v;
    dma_req_in <= v[3:0];
    dma_gnt2_out <= v[4];
    audio_reset_n <= ~v[2];
    audio_sync <= ~v[4];
    audio_sdout <= ~v[7];
    gpio_lo_out <= v[7:5];
    gpio_lo_pin_in <= ~v[6:4];
  endtask

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end

  initial begin
    set_pins(8'h00);
    for (int i = 0; i < 4; i++) begin
      d = pats[i];
      a = 20'h8_1CE6;
      a[18] = i[0];
      a[9] = i[1];
      bd <= d;
      ba <= a;
      set_pins(d[7:0] ^ 8'h96);
      reset <= 1'b1;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      e = 32'({d[15:8], ~d[7], d[1:0]});
      chk(32'({board_boot_field, core_timer_irq_off, boot_width}), e);
      e = 32'h0000_0000;
      e[bsp_pkg::CC_BOARD_BOOT_FIELD_LSB +: 8] = d[15:8];
      e[bsp_pkg::CC_TIMER_BIT] = ~d[7];
      e[bsp_pkg::CC_ARB_BIT] = d[2];
      apb(1'b0, bsp_pkg::ADDR_CHIP_CONFIG, 32'h0000_0000);
      chk(rd, e);
      e = 32'h0000_0000;
      e[bsp_pkg::EB_WIDTH_LSB +: 2] = d[1:0];
      e[bsp_pkg::EB_WAIT_LSB] = d[4];
      e[bsp_pkg::EB_STROBE_BIT] = d[5];
      apb(1'b0, bsp_pkg::ADDR_EXT_BUS_CH0, 32'h0000_0000);
      chk(rd, e);
      e = 32'h0000_0000;
      e[bsp_pkg::PM_ECC_BIT] = a[18];
      e[bsp_pkg::PM_AUDIO_BIT] = a[9];
      apb(1'b0, bsp_pkg::ADDR_PIN_MUX, 32'h0000_0000);
      chk(rd, e);
      chk(32'(cb_pin_out), 32'(a[18] ? ecc_check_bits_out : gpio_hi_out));
      chk(32'(gpio_hi_in), 32'(a[18] ? 8'h00 : cb_pin_in));
      chk(32'(ecc_check_bits_in), 32'(a[18] ? cb_pin_in : 8'h00));
      chk(32'(cb_pin_oe), 32'(a[18] ? ecc_check_bits_oe : gpio_hi_oe));
      e = 32'(dma_req_in);
      e[2] = a[9] ? audio_reset_n : dma_req_in[2];
      chk(32'(dma_request_pins), e);
      e = a[9] ? 32'({audio_sync, audio_sdout, 2'h0}) : 32'({dma_gnt2_out, gpio_lo_out});
      chk(32'({dma_grant2_pin, gpio_lo_pin_out}), e);
      e = a[9] ? 32'({3'h4, 3'h0}) : 32'({gpio_lo_oe, gpio_lo_pin_in});
      chk(32'({gpio_lo_pin_oe, gpio_lo_in}), e);
      chk(32'({audio_sdin, audio_bitclk}), 32'(a[9] ? gpio_lo_pin_in[3:2] : 2'b00));
    end
    apb(1'b1, bsp_pkg::ADDR_STRAP_RAW, 32'hFFFF_FFFF);
    apb(1'b0, bsp_pkg::ADDR_STRAP_RAW, 32'h0000_0000);
    chk(rd, {14'h0000, a[18], a[9], d});
    apb(1'b1, bsp_pkg::ADDR_PIN_MUX, 32'h0000_0000);
    // the write lands on the edge the task returns at; look one edge later
    @(posedge ref_clk);
    chk(32'({ecc_sel, audio_sel, cb_pin_out}), 32'({2'b00, gpio_hi_out}));
    chk(32'(dma_request_pins), 32'(dma_req_in));
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    repeat (20) @(posedge ref_clk);
    chk(32'(board_boot_field), 32'(d[15:8]));
    end_sim();
  end
endmodule
